/* rtl/fault_blank_chop.sv */
// one generator's fault, current-limit, blanking and chop conditioning
// ----------------------------------------------------------------
// Notes on behaviour
// - fault selector: codes 0-6 pick fault pins 1-7, 8-10 comparators 1-3.
// - polarity bit set means the selected fault source is active low.
// - mode 00: active fault forces both pins to override values, latched.
// - mode 01: active fault forces both pins cycle by cycle, no latch.
// - mode 11 disables fault input; mode 10 reserved, treated as disabled.
// - four enables let each edge of high and low output start blanking.
// - separate enables apply blanking to fault and to current-limit inputs.
// - 12-bit blanking delay shared by both inputs; upper bits read zero.
// - four enables mask inputs by high/low level of each output.
// - two enables mask inputs while selected blank signal is high or low.
// - blank source: 0 none, 1-7 high output of generators 1-7.
// - chop source: 0 internal chop clock, 1-7 generator high outputs.
// - chop enable set: selected source alternately gates that output.
// - independent mode: limit forces high pin, fault forces low pin.
// ----------------------------------------------------------------
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/1ps
module fault_blank_chop
  import fault_blank_pkg::*;
(
  input  wire logic                       clock_i,     // 250 MHz module clock
  input  wire logic                       rst_b_i,     // async reset, active low
  input  wire fault_blank_pkg::reg_req_t  req_i,       // register port request
  output logic [15:0]                     rdata_o,     // read data, cycle after rd
  input  wire fault_blank_pkg::ext_in_t   ext_i,       // fault pins, comparators, gens
  input  wire fault_blank_pkg::pin_pair_t gen_i,       // raw generator outputs
  input  wire logic                       cycle_start_i, // pwm period start pulse
  output fault_blank_pkg::pin_pair_t      pins_o,      // conditioned power-stage outputs
  output logic                            fault_o,     // fault override in force
  output logic                            limit_o      // current limit in force
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  rst_sync;
    logic [15:0] fcl;
    logic [15:0] trig;
    logic [15:0] dly;
    logic [15:0] aux;
    logic [15:0] ovr;
    logic [15:0] rdata;
    logic        flt_latch;
    logic        flt_cycle;
    logic        cl_cycle;
    pin_pair_t   pins;
  } top_state_t;

  top_state_t s_q;
  top_state_t s_d;
  logic       rst_b;
  logic       leb_active;
  logic       flt_raw;
  logic       cl_raw;
  logic       state_blank;
  logic       flt_act;
  logic       cl_act;
  logic       blank_sig;
  logic       chop_sig;
  logic [1:0] fdat;

  assign rst_b = s_q.rst_sync[1];

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // source decode, reserved codes read 0, which is active when the polarity bit is set
  function automatic logic pick_source(input logic [4:0] code, input ext_in_t e);
    logic v;
    v = 1'b0;
    if (code <= SRC_FAULT_LAST) begin
      v = e.fault_pins[code[2:0]];
    end else if (code >= SRC_CMP_FIRST && code <= SRC_CMP_LAST) begin
      v = e.comparators[2'(code - SRC_CMP_FIRST)];
    end
    return v;
  endfunction : pick_source

  // generator 1..7 high output, code 0 yields the fallback
  function automatic logic pick_gen(input logic [3:0] code, input ext_in_t e,
                                    input logic zero_val);
    logic v;
    v = 1'b0;
    if (code == 4'h0) begin
      v = zero_val;
    end else if (code <= GEN_SEL_LAST) begin
      v = e.gen_high[3'(code - 4'h1)];
    end
    return v;
  endfunction : pick_gen

  function automatic logic [15:0] merge(input logic [15:0] old_v, input logic [15:0] new_v,
                                        input logic [15:0] mask);
    return (old_v & ~mask) | (new_v & mask);
  endfunction : merge

  // ----------------------------------------------------------------
  // blanking timer
  // ----------------------------------------------------------------
  blank_timer u_blank_timer (
    .clock_i   (clock_i),
    .rst_b_i   (rst_b),
    .pins_i    (gen_i),
    .trig_en_i (s_q.trig[HR_TRIG_BIT:LF_TRIG_BIT]),
    .delay_i   (s_q.dly[DLY_W-1:0]),
    .active_o  (leb_active)
  );

  // ----------------------------------------------------------------
  // input conditioning
  // ----------------------------------------------------------------
  always_comb begin
    // state blank source select, code 0 means none
    blank_sig = pick_gen(s_q.aux[BLANK_SEL_LSB +: 4], ext_i, 1'b0);
    chop_sig  = pick_gen(s_q.aux[CHOP_SEL_LSB +: 4], ext_i, ext_i.chop_clock);
    flt_raw = pick_source(s_q.fcl[FLT_SRC_LSB +: 5], ext_i) ^ s_q.fcl[FLT_POL_BIT];
    cl_raw  = pick_source(s_q.fcl[CL_SRC_LSB +: 5], ext_i) ^ s_q.fcl[CL_POL_BIT];
    state_blank = (s_q.trig[HH_BIT] &  gen_i.hi) | (s_q.trig[HL_BIT] & ~gen_i.hi) |
                  (s_q.trig[LH_BIT] &  gen_i.lo) | (s_q.trig[LL_BIT] & ~gen_i.lo);
    if (s_q.aux[BLANK_SEL_LSB +: 4] != 4'h0) begin
      state_blank = state_blank | (s_q.trig[SIG_HI_BIT] & blank_sig) |
                    (s_q.trig[SIG_LO_BIT] & ~blank_sig);
    end
    flt_act = flt_raw & ~state_blank & ~(s_q.trig[FLT_LEB_BIT] & leb_active);
    cl_act  = cl_raw  & ~state_blank & ~(s_q.trig[CL_LEB_BIT] & leb_active);
  end

  assign fdat = s_q.ovr[FDAT_LSB +: 2];

  // ----------------------------------------------------------------
  // registers, fault state and outputs
  // ----------------------------------------------------------------
  always_comb begin
    s_d          = s_q;
    s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
    s_d.rdata    = '0;

    // register writes; masks keep unimplemented bits at zero
    if (req_i.wr && req_i.addr[15:4] == 12'h000) begin
      unique case (req_i.addr[3:0])
        FCL_CTRL_OFS:   s_d.fcl  = merge(s_q.fcl, req_i.wdata, FCL_CTRL_MASK);
        BLANK_TRIG_OFS: s_d.trig = merge(s_q.trig, req_i.wdata, BLANK_TRIG_MASK);
        BLANK_DLY_OFS:  s_d.dly  = merge(s_q.dly, req_i.wdata, BLANK_DLY_MASK);
        BLANK_CHOP_OFS: s_d.aux  = merge(s_q.aux, req_i.wdata, BLANK_CHOP_MASK);
        OVR_CTRL_OFS:   s_d.ovr  = merge(s_q.ovr, req_i.wdata, OVR_CTRL_MASK);
        default: ;
      endcase
    end

    if (req_i.rd) begin
      if (req_i.addr[15:4] == 12'h000) begin
        unique case (req_i.addr[3:0])
          FCL_CTRL_OFS:   s_d.rdata = s_q.fcl;
          BLANK_TRIG_OFS: s_d.rdata = s_q.trig;
          BLANK_DLY_OFS:  s_d.rdata = s_q.dly;
          BLANK_CHOP_OFS: s_d.rdata = s_q.aux;
          OVR_CTRL_OFS:   s_d.rdata = s_q.ovr;
          STATUS_OFS:     s_d.rdata = {12'h000, leb_active, s_q.cl_cycle,
                                       s_q.flt_cycle, s_q.flt_latch};
          default:        s_d.rdata = '0;
        endcase
      end
    end

    // fault response; mode only acts while the override is enabled
    unique case (s_q.fcl[FLT_MODE_LSB +: 2])
      // latched until cleared by mode change or disabled block
      MODE_LATCHED: begin
        s_d.flt_cycle = 1'b0;
        if (flt_act) begin
          s_d.flt_latch = 1'b1;
        end
      end
      // held to end of the pwm cycle, then re-evaluated
      MODE_CYCLE: begin
        s_d.flt_latch = 1'b0;
        if (flt_act) begin
          s_d.flt_cycle = 1'b1;
        end else if (cycle_start_i) begin
          s_d.flt_cycle = 1'b0;
        end
      end
      // disabled and reserved codes ignore the input
      default: begin
        s_d.flt_latch = 1'b0;
        s_d.flt_cycle = 1'b0;
      end
    endcase
    // a cleared override enable clears both fault states, winning over any set
    if (!s_q.ovr[OVR_EN_BIT]) begin
      s_d.flt_latch = 1'b0;
      s_d.flt_cycle = 1'b0;
    end

    // current limit is cycle by cycle when its mode bit is set
    if (s_q.fcl[CL_MODE_BIT] && s_q.ovr[OVR_EN_BIT] && cl_act) begin
      s_d.cl_cycle = 1'b1;
    end else if (cycle_start_i || !s_q.fcl[CL_MODE_BIT]) begin
      s_d.cl_cycle = 1'b0;
    end

    // chop gating ahead of fault overrides
    s_d.pins.hi = gen_i.hi & (~s_q.aux[CHOP_H_BIT] | chop_sig);
    s_d.pins.lo = gen_i.lo & (~s_q.aux[CHOP_L_BIT] | chop_sig);

    if (s_q.fcl[INDEP_BIT]) begin
      // limit drives high pin, fault drives low pin
      if (s_d.cl_cycle) begin
        s_d.pins.hi = fdat[1];
      end
      if (s_d.flt_latch || s_d.flt_cycle) begin
        s_d.pins.lo = fdat[0];
      end
    end else if (s_d.flt_latch || s_d.flt_cycle) begin
      s_d.pins.hi = fdat[1];
      s_d.pins.lo = fdat[0];
    end

    // hold everything clear until the reset copy has let go
    if (!s_q.rst_sync[1]) begin
      s_d          = '0;
      s_d.rst_sync = {s_q.rst_sync[0], 1'b1};
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign pins_o  = s_q.pins;
  assign fault_o = s_q.flt_latch | s_q.flt_cycle;
  assign limit_o = s_q.cl_cycle;

endmodule : fault_blank_chop

/* rtl/fault_blank_pkg.sv */
// package: register map, field positions and types for the fault/blanking/chop block
package fault_blank_pkg;

  // ----------------------------------------------------------------
  // register offsets (word addresses on the plain register port)
  // ----------------------------------------------------------------
  localparam logic [3:0] FCL_CTRL_OFS   = 4'h0;
  localparam logic [3:0] BLANK_TRIG_OFS = 4'h1;
  localparam logic [3:0] BLANK_DLY_OFS  = 4'h2;
  localparam logic [3:0] BLANK_CHOP_OFS = 4'h3;
  localparam logic [3:0] OVR_CTRL_OFS   = 4'h4;
  localparam logic [3:0] STATUS_OFS     = 4'h5;

  // ----------------------------------------------------------------
  // reset values and write masks
  // ----------------------------------------------------------------
  localparam logic [15:0] REG_RESET       = 16'h0000;
  localparam logic [15:0] FCL_CTRL_MASK   = 16'hFFFF;
  localparam logic [15:0] BLANK_TRIG_MASK = 16'hFC3F;
  localparam logic [15:0] BLANK_DLY_MASK  = 16'h0FFF;
  localparam logic [15:0] BLANK_CHOP_MASK = 16'h0F3F;
  localparam logic [15:0] OVR_CTRL_MASK   = 16'h0007;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int INDEP_BIT      = 15;
  localparam int CL_SRC_LSB     = 10;
  localparam int CL_POL_BIT     = 9;
  localparam int CL_MODE_BIT    = 8;
  localparam int FLT_SRC_LSB    = 3;
  localparam int FLT_POL_BIT    = 2;
  localparam int FLT_MODE_LSB   = 0;
  localparam int HR_TRIG_BIT    = 15;
  localparam int HF_TRIG_BIT    = 14;
  localparam int LR_TRIG_BIT    = 13;
  localparam int LF_TRIG_BIT    = 12;
  localparam int FLT_LEB_BIT    = 11;
  localparam int CL_LEB_BIT     = 10;
  localparam int SIG_HI_BIT     = 5;
  localparam int SIG_LO_BIT     = 4;
  localparam int HH_BIT         = 3;
  localparam int HL_BIT         = 2;
  localparam int LH_BIT         = 1;
  localparam int LL_BIT         = 0;
  localparam int BLANK_SEL_LSB  = 8;
  localparam int CHOP_SEL_LSB   = 2;
  localparam int CHOP_H_BIT     = 1;
  localparam int CHOP_L_BIT     = 0;
  localparam int OVR_EN_BIT     = 0;
  localparam int FDAT_LSB       = 1;

  // ----------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------
  localparam logic [4:0]  SRC_FAULT_LAST = 5'h06;
  localparam logic [4:0]  SRC_CMP_FIRST  = 5'h08;
  localparam logic [4:0]  SRC_CMP_LAST   = 5'h0A;
  localparam logic [1:0]  MODE_LATCHED   = 2'h0;
  localparam logic [1:0]  MODE_CYCLE     = 2'h1;
  localparam logic [1:0]  MODE_OFF       = 2'h3;
  localparam logic [3:0]  GEN_SEL_LAST   = 4'h7;
  localparam int          DLY_W          = 12;

  // output pin pair and external signal bundles
  typedef struct packed {
    logic hi;
    logic lo;
  } pin_pair_t;

  typedef struct packed {
    logic [6:0] fault_pins;
    logic [2:0] comparators;
    logic [6:0] gen_high;
    logic       chop_clock;
  } ext_in_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

endpackage : fault_blank_pkg

/* rtl/blank_timer.sv */
// leading-edge blanking timer: edge detection and 12-bit delay counter
`timescale 1ns/1ps
module blank_timer
  import fault_blank_pkg::*;
(
  input  wire logic                 clock_i,    // module clock
  input  wire logic                 rst_b_i,    // synchronised reset, active low
  input  wire fault_blank_pkg::pin_pair_t pins_i, // generator outputs before override
  input  wire logic [3:0]           trig_en_i,  // hr, hf, lr, lf enables
  input  wire logic [DLY_W-1:0]     delay_i,    // blanking length in cycles
  output logic                      active_o    // blanking window open
);

  typedef struct packed {
    pin_pair_t        prev;
    logic [DLY_W-1:0] count;
    logic             run;
  } timer_state_t;

  timer_state_t s_q;
  timer_state_t s_d;
  logic         trig;

  assign trig = (trig_en_i[3] &  pins_i.hi & ~s_q.prev.hi) |
                (trig_en_i[2] & ~pins_i.hi &  s_q.prev.hi) |
                (trig_en_i[1] &  pins_i.lo & ~s_q.prev.lo) |
                (trig_en_i[0] & ~pins_i.lo &  s_q.prev.lo);

  always_comb begin
    s_d      = s_q;
    s_d.prev = pins_i;
    if (trig) begin
      s_d.count = '0;
      s_d.run   = (delay_i != '0);
    end else if (s_q.run) begin
      s_d.count = s_q.count + 1'b1;
      if (s_d.count >= delay_i) begin
        s_d.run = 1'b0;
      end
    end
  end

  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // window covers the trigger cycle too, so the edge itself is masked
  assign active_o = s_q.run | (trig & (delay_i != '0));

endmodule : blank_timer

/* verif/fault_blank_chop_checker.sv */
// assertion checker for the fault, blanking and chop block
`timescale 1ns/1ps
module fault_blank_chop_checker (
  input wire logic                       clock_i,       // module clock
  input wire logic                       rst_b_i,       // reset, active low
  input wire fault_blank_pkg::reg_req_t  req_i,         // register request
  input wire logic [15:0]                rdata_o,       // read data
  input wire fault_blank_pkg::ext_in_t   ext_i,         // far side lines
  input wire fault_blank_pkg::pin_pair_t gen_i,         // raw outputs
  input wire logic                       cycle_start_i, // period start
  input wire fault_blank_pkg::pin_pair_t pins_o,        // conditioned outputs
  input wire logic                       fault_o,       // fault in force
  input wire logic                       limit_o        // limit in force
);
  import fault_blank_pkg::*;
  // shadow copies of the control words, written on the design's writes but without its write masks
  logic [15:0] fcl_q, trig_q, aux_q, ovr_q;
  logic [1:0]  up_q;
  logic        rdy;
  logic        calm;
  always_ff @(posedge clock_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      {fcl_q, trig_q, aux_q, ovr_q} <= '0;
      up_q <= '0;
    end else begin
      if (up_q != 2'd3) up_q <= up_q + 2'd1;
      if (req_i.wr && req_i.addr == {12'h000, FCL_CTRL_OFS}) fcl_q <= req_i.wdata;
      if (req_i.wr && req_i.addr == {12'h000, BLANK_TRIG_OFS}) trig_q <= req_i.wdata;
      if (req_i.wr && req_i.addr == {12'h000, BLANK_CHOP_OFS}) aux_q <= req_i.wdata;
      if (req_i.wr && req_i.addr == {12'h000, OVR_CTRL_OFS}) ovr_q <= req_i.wdata;
    end
  end
  // internal reset copy needs a few edges to let go
  assign rdy  = up_q == 2'd3;
  assign calm = rdy && trig_q == 16'h0000 && fcl_q[15:8] == 8'h00 && !req_i.wr;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_b_i);
  property p_rdata_idle; rdy && !$past(req_i.rd) |-> rdata_o == 16'h0000; endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside slot");
  property p_dly_top; req_i.rd && req_i.addr == 16'h0002 |=> rdata_o[15:12] == 4'h0; endproperty
  a_dly_top: assert property (p_dly_top) else $error("delay upper bits set");
  property p_fault_force;
    calm && ovr_q[0] && fcl_q[7:0] == 8'h00 && ext_i.fault_pins[0]
      |=> fault_o && pins_o == ovr_q[2:1];
  endproperty
  a_fault_force: assert property (p_fault_force) else $error("fault not forced");
  property p_polarity;
    calm && ovr_q[0] && fcl_q[7:0] == 8'h04 && !ext_i.fault_pins[0] |=> fault_o;
  endproperty
  a_polarity: assert property (p_polarity) else $error("low fault ignored");
  property p_latch_hold;
    rdy && fault_o && fcl_q[1:0] == MODE_LATCHED && $past(fcl_q[1:0]) == MODE_LATCHED &&
      ovr_q[0] && !req_i.wr |=> fault_o;
  endproperty
  a_latch_hold: assert property (p_latch_hold) else $error("latched fault lost");
  property p_mode_off; rdy && fcl_q[1] && $past(fcl_q[1]) |-> !fault_o; endproperty
  a_mode_off: assert property (p_mode_off) else $error("fault while disabled");
  property p_rsvd_src;
    rdy && fcl_q[7:2] == 6'h0E && $past(fcl_q[7:2]) == 6'h0E |-> !$rose(fault_o);
  endproperty
  a_rsvd_src: assert property (p_rsvd_src) else $error("reserved source fired");
  property p_chop_gate;
    rdy && aux_q[5:1] == 5'b00001 && !ovr_q[0] && !ext_i.chop_clock && !req_i.wr
      |=> fault_o || limit_o || !pins_o.hi;
  endproperty
  a_chop_gate: assert property (p_chop_gate) else $error("chop did not gate");
  c_force: cover property (rdy && $rose(fault_o));
  c_chop: cover property (rdy && aux_q[1] && $fell(pins_o.hi));
  c_read: cover property (req_i.rd ##1 rdata_o != 16'h0000);
endmodule : fault_blank_chop_checker

bind fault_blank_chop fault_blank_chop_checker u_chk (.clock_i(clock_i), .rst_b_i(rst_b_i),
  .req_i(req_i), .rdata_o(rdata_o), .ext_i(ext_i), .gen_i(gen_i),
  .cycle_start_i(cycle_start_i), .pins_o(pins_o), .fault_o(fault_o), .limit_o(limit_o));

/* verif/fault_side_model.sv */
// far side model: fault pins, comparators, generator and chop lines
`timescale 1ns/1ps
module fault_side_model (
  input  wire logic [4:0]         src_i,  // line to exercise
  input  wire logic               act_i,  // fault condition present
  input  wire logic               low_i,  // lines idle high, active low
  input  wire logic               chop_i, // chop clock level
  input  wire logic [6:0]         gens_i, // other generators' high outputs
  output fault_blank_pkg::ext_in_t ext_o  // lines toward the block
);
  import fault_blank_pkg::*;
  // unused lines sit at their idle level so only one source acts
  always_comb begin
    ext_o.fault_pins  = {7{low_i}};
    ext_o.comparators = {3{low_i}};
    ext_o.gen_high    = gens_i;
    ext_o.chop_clock  = chop_i;
    if (src_i <= SRC_FAULT_LAST) ext_o.fault_pins[src_i[2:0]] = act_i ^ low_i;
    else if (src_i >= SRC_CMP_FIRST && src_i <= SRC_CMP_LAST)
      ext_o.comparators[src_i[1:0]] = act_i ^ low_i;
  end
endmodule : fault_side_model

/* verif/fault_blank_chop_tb.sv */
// self-checking bench for the fault, blanking and chop block
`timescale 1ns/1ps
module fault_blank_chop_tb;
  import fault_blank_pkg::*;
  logic        clock_i = 1'b0;
  logic        rst_b_i = 1'b0;
  reg_req_t    req     = '0;
  pin_pair_t   gen     = '0;
  pin_pair_t   pins;
  ext_in_t     ext;
  logic        cyc     = 1'b0;
  logic        act     = 1'b0;
  logic        low     = 1'b0;
  logic        chop    = 1'b0;
  logic [4:0]  src     = '0;
  logic [6:0]  gens    = '0;
  logic [15:0] rdata;
  logic        flt;
  logic        lim;
  int          error_cnt = 0;
  int          checks    = 0;
  int          cyc_cnt   = 0;
  always #2 clock_i = ~clock_i;
  fault_side_model far (.src_i(src), .act_i(act), .low_i(low), .chop_i(chop), .gens_i(gens),
    .ext_o(ext));
  fault_blank_chop DUT (.clock_i(clock_i), .rst_b_i(rst_b_i), .req_i(req), .rdata_o(rdata),
    .ext_i(ext), .gen_i(gen), .cycle_start_i(cyc), .pins_o(pins), .fault_o(flt),
    .limit_o(lim));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : close_out
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock_i);
    req.addr  <= {12'h000, a};
    req.wdata <= d;
    req.wr    <= 1'b1;
    @(posedge clock_i) req.wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock_i);
    req.addr <= {12'h000, a};
    req.rd   <= 1'b1;
    @(posedge clock_i) req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd
  // limit path stays off; its selector stays on fault pin 1, shared when the fault code is 0
  task automatic cfg(input logic [4:0] s, input logic p, input logic [1:0] m);
    @(posedge clock_i) src <= s;
    wr(FCL_CTRL_OFS, {8'h00, s, p, m});
  endtask : cfg
  task automatic quiet();
    @(posedge clock_i);
    act  <= 1'b0;
    gen  <= '0;
    gens <= '0;
    cyc  <= 1'b1;
    @(posedge clock_i) cyc <= 1'b0;
    tick(2);
  endtask : quiet
  task automatic set_in(input pin_pair_t g, input logic [6:0] o);
    @(posedge clock_i);
    gen  <= g;
    gens <= o;
    act  <= 1'b1;
  endtask : set_in
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic regs();
    logic [15:0] mask [5];
    logic [15:0] d;
    mask = '{FCL_CTRL_MASK, BLANK_TRIG_MASK, BLANK_DLY_MASK, BLANK_CHOP_MASK, OVR_CTRL_MASK};
    for (int i = 0; i < 6; i++) begin
      rd(4'(i), d);
      chk(d, REG_RESET, "reset value");
    end
    for (int i = 0; i < 5; i++) begin
      wr(4'(i), 16'hFFFF);
      rd(4'(i), d);
      chk(d, mask[i], "readback");
    end
    wr(4'h6, 16'hFFFF);
    rd(4'h6, d);
    chk(d, 16'h0000, "unmapped read");
    for (int i = 0; i < 5; i++) wr(4'(i), 16'h0000);
    quiet();
  endtask : regs
  task automatic faults();
    logic [4:0] codes [11];
    codes = '{0, 1, 2, 3, 4, 5, 6, 8, 9, 10, 7};
    wr(OVR_CTRL_OFS, 16'h0005);
    foreach (codes[i]) begin
      cfg(codes[i], 1'b0, MODE_LATCHED);
      set_in('0, '0);
      tick(1);
      chk(flt, codes[i] != 5'd7, "fault on source");
      chk(pins, codes[i] == 5'd7 ? 2'b00 : 2'b10, "override data");
      @(posedge clock_i) act <= 1'b0;
      tick(2);
      chk(flt, codes[i] != 5'd7, "fault latched");
      cfg(codes[i], 1'b0, MODE_OFF);
      tick(1);
      chk(flt, 1'b0, "fault cleared");
    end
    @(posedge clock_i) low <= 1'b1;
    cfg(5'd0, 1'b1, MODE_LATCHED);
    tick(2);
    chk(flt, 1'b0, "idle high line");
    set_in('0, '0);
    tick(1);
    chk(flt, 1'b1, "active low line");
    cfg(5'd0, 1'b1, MODE_OFF);
    @(posedge clock_i) low <= 1'b0;
    quiet();
  endtask : faults
  task automatic modes();
    cfg(5'd0, 1'b0, MODE_CYCLE);
    set_in('0, '0);
    tick(1);
    chk(flt, 1'b1, "cycle fault");
    @(posedge clock_i) act <= 1'b0;
    tick(3);
    chk(flt, 1'b1, "held to period end");
    quiet();
    chk(flt, 1'b0, "released at period start");
    for (int m = 2; m < 4; m++) begin
      cfg(5'd0, 1'b0, 2'(m));
      set_in('0, '0);
      tick(2);
      chk({flt, pins}, 3'b000, "fault input off");
      quiet();
    end
  endtask : modes
  task automatic blanking();
    int n;
    wr(BLANK_DLY_OFS, 16'h0008);
    wr(BLANK_TRIG_OFS, 16'h8800);
    cfg(5'd0, 1'b0, MODE_CYCLE);
    set_in(2'b10, '0);
    tick(6);
    chk(flt, 1'b0, "masked after rising edge");
    n = 0;
    while (flt !== 1'b1 && n < 20) begin
      tick(1);
      n++;
    end
    chk(flt, 1'b1, "fault after blanking");
    // delay 8 masks the trigger sample and eight more
    chk(16'(n), 16'd4, "blanking length");
    quiet();
    wr(BLANK_TRIG_OFS, 16'h8400);
    set_in(2'b10, '0);
    tick(1);
    chk(flt, 1'b1, "fault not blanked");
    quiet();
    wr(BLANK_TRIG_OFS, 16'h0008);
    set_in(2'b10, '0);
    tick(3);
    chk(flt, 1'b0, "blanked by high level");
    @(posedge clock_i) gen.hi <= 1'b0;
    tick(1);
    chk(flt, 1'b1, "fault once low");
    quiet();
    wr(BLANK_CHOP_OFS, 16'h0300);
    wr(BLANK_TRIG_OFS, 16'h0020);
    set_in('0, 7'h04);
    tick(3);
    chk(flt, 1'b0, "blanked by generator 3");
    @(posedge clock_i) gens <= 7'h00;
    tick(1);
    chk(flt, 1'b1, "fault once signal low");
    quiet();
    wr(BLANK_TRIG_OFS, 16'h0000);
  endtask : blanking
  task automatic chopping();
    cfg(5'd0, 1'b0, MODE_OFF);
    wr(OVR_CTRL_OFS, 16'h0000);
    @(posedge clock_i) gen <= 2'b11;
    for (int s = 0; s < 8; s += 3) begin
      wr(BLANK_CHOP_OFS, 16'(s << 2) | 16'h0002);
      for (int v = 0; v < 2; v++) begin
        @(posedge clock_i);
        chop <= (s == 0) ? v[0] : ~v[0];
        gens <= (s == 0) ? ~{7{v[0]}} : 7'(v << (s - 1));
        tick(1);
        chk(pins, {v[0], 1'b1}, "chop gate");
      end
    end
    wr(BLANK_CHOP_OFS, 16'h0001);
    @(posedge clock_i) chop <= 1'b0;
    tick(1);
    chk(pins, 2'b10, "chop low gate");
  endtask : chopping
  task automatic indep();
    wr(BLANK_CHOP_OFS, 16'h0000);
    wr(OVR_CTRL_OFS, 16'h0007);
    // limit on fault pin 1, fault selector parked on an unused code
    wr(FCL_CTRL_OFS, 16'h8139);
    set_in('0, '0);
    tick(1);
    chk({lim, flt, pins}, 4'b1010, "limit forces high pin");
    quiet();
    chk(lim, 1'b0, "limit released at period start");
    wr(FCL_CTRL_OFS, 16'h9D01);
    set_in('0, '0);
    tick(1);
    chk({lim, flt, pins}, 4'b0101, "fault forces low pin");
    quiet();
    wr(FCL_CTRL_OFS, 16'h0000);
    wr(OVR_CTRL_OFS, 16'h0000);
  endtask : indep
  // hang guard, the full run takes well under two thousand cycles
  always @(posedge clock_i) begin
    cyc_cnt++;
    if (cyc_cnt == 5000) begin
      error_cnt++;
      close_out();
    end
  end
  initial begin
    repeat (10) @(posedge clock_i);
    rst_b_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    regs();
    faults();
    modes();
    blanking();
    chopping();
    indep();
    close_out();
  end
endmodule : fault_blank_chop_tb
